// >>> logic/anc_tc_params.svh
// Constants for the ancillary timecode inserter
`ifndef ANC_TC_PARAMS_SVH
`define ANC_TC_PARAMS_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_IDS 8'h04
`define REG_LINE 8'h08
`define REG_LOC 8'h0c
`define REG_STAT 8'h10
// Control register fields, and the override bit of the line register
`define CTRL_EN 0
`define CTRL_VITC 1
`define CTRL_GPI 2
`define CTRL_FMT_LO 3
`define CTRL_HIRATE 5
`define CTRL_R25 6
`define LINE_OVR 16
// Reset values
`define DID_RST 8'h60
`define SDID_RST 8'h60
`define LOC_RST 12'h000
// Default lines
`define L480_F1 11'h00c
`define L480_F2 11'h113
`define L576_F1 11'h008
`define L576_F2 11'h141
`define LHD_LTC 11'h00a
`define LHDI_V2 11'h23b
`define LHDP_V2 11'h009
// Packet layout
`define ADF0 10'h000
`define ADF1 10'h3ff
`define PKT_DC 8'h10
`define IX_DID 5'h03
`define IX_SDID 5'h04
`define IX_DC 5'h05
`define IX_UDW 5'h06
`define IX_CS 5'h16
`define PKT_LEN 5'h17
// Field mark position in the 64-bit timecode payload
`define FM_30 6'h1b
`define FM_25 6'h3b
`endif

// >>> logic/anc_tc_pkg.sv
// Types shared by the ancillary timecode inserter
package anc_tc_pkg;
   typedef struct packed {
      logic sof;
      logic field;
      logic hblank;
      logic [10:0] line;
      logic [9:0] c;
      logic [9:0] y;
   } vid_t;
   typedef struct packed {
      logic stb;
      logic [63:0] bits;
   } tc_in_t;
   typedef enum logic [1:0] {FMT_480I, FMT_576I, FMT_HDI, FMT_HDP} fmt_t;
   typedef enum logic {ST_IDLE, ST_SEND} st_t;
endpackage : anc_tc_pkg

// >>> logic/skid2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module skid2 #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rp_q];

   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule : skid2

// >>> logic/anc_timecode_inserter.sv
// Inserts received timecode as an ancillary packet into the video stream
//
// Summary of operation
// - Timecode digits and binary groups pass unchanged; only field mark set.
// - Interlaced: field mark 0 in first field, 1 in second field.
// - Progressive: 0 at or below 30Hz; above, 0 then 1 per pair.
// - Field mark sits at UDW 7 bit 7, or UDW 15 bit 7 at 25fps.
// - SD default lines 12/275 for 480i and 8/321 for 576i.
// - HD interlaced default: LTC on line 10, second VITC on 571.
// - HD progressive default: LTC on line 10, second VITC on 9.
// - Timecode source selectable between balanced serial and GPI input.
// - Only the selected source is taken; the other is ignored.
// - In HD, mode chooses one LTC packet or a pair of VITC packets; SD sends a pair unless the line override is set.
// - Packet DID comes from a software register.
// - Packet SDID comes from a software register.
// - Programmable encode line replaces the format default line.
// - HD and 3G: packet placed in the luma channel only.
// - SD: packet placed across interleaved chroma and luma words.
// - Location setting picks the word offset within blanking.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`include "anc_tc_params.svh"
`timescale 1ns/1ps
module anc_timecode_inserter (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire anc_tc_pkg::tc_in_t ser_tc,
   input wire anc_tc_pkg::tc_in_t gpi_tc,
   input wire logic in_valid,
   output logic in_ready,
   input wire anc_tc_pkg::vid_t in_word,
   output logic out_valid,
   input wire logic out_ready,
   output anc_tc_pkg::vid_t out_word
);
   logic [6:0] ctrl_q;
   logic [7:0] did_q;
   logic [7:0] sdid_q;
   logic [10:0] ovr_line_q;
   logic ovr_en_q;
   logic [11:0] loc_q;
   logic [63:0] tc_q;
   logic tc_valid_q;
   logic [7:0] pkt_cnt_q;
   logic [11:0] hpos_q;
   logic pair_q;
   anc_tc_pkg::st_t st_q;
   logic [4:0] idx_q;
   logic [63:0] ptc_q;
   logic [9:0] cs_q;
   logic fire;
   logic active;
   logic hit;
   logic sending;
   logic is_sd;
   logic fm_val;
   logic [5:0] fm_pos;
   logic [10:0] line_a;
   logic [10:0] line_b;
   logic line_b_en;
   logic [63:0] tc_fm;
   logic [63:0] t_use;
   logic [9:0] cs_new;
   logic [9:0] cs_use;
   logic [4:0] cur_idx;
   logic [4:0] nxt_idx;
   logic [9:0] w0;
   logic [9:0] w1;
   anc_tc_pkg::vid_t mod_word;
   anc_tc_pkg::fmt_t fmt;
   anc_tc_pkg::tc_in_t sel_tc;

   assign fmt = anc_tc_pkg::fmt_t'(ctrl_q[`CTRL_FMT_LO+:2]);
   assign is_sd = (fmt == anc_tc_pkg::FMT_480I) ||
                  (fmt == anc_tc_pkg::FMT_576I);
   assign fire = in_valid && in_ready;

   // Word with even parity in bit 8 and its inverse in bit 9
   function automatic logic [9:0] with_par(input logic [7:0] b);
      with_par = {~(^b), ^b, b};
   endfunction : with_par

   // One packet word, checksum slot excluded
   function automatic logic [9:0] pkt_word(input logic [4:0] i,
         input logic [63:0] t, input logic [7:0] d, input logic [7:0] s);
      logic [3:0] nib;
      logic [4:0] k;
      k = 5'(i - `IX_UDW);
      nib = 4'(t >> {k, 2'b00});
      if (i == 5'h00) begin
         pkt_word = `ADF0;
      end else if (i < `IX_DID) begin
         pkt_word = `ADF1;
      end else if (i == `IX_DID) begin
         pkt_word = with_par(d);
      end else if (i == `IX_SDID) begin
         pkt_word = with_par(s);
      end else if (i == `IX_DC) begin
         pkt_word = with_par(`PKT_DC);
      end else begin
         pkt_word = with_par({nib, 4'h0}); // Nibble in b7..b4
      end
   endfunction : pkt_word

   // Register writes: control, identifiers, line and location
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 7'h00;
         did_q <= `DID_RST;
         sdid_q <= `SDID_RST;
         ovr_line_q <= 11'h000;
         ovr_en_q <= 1'b0;
         loc_q <= `LOC_RST;
      end else if (wr) begin
         case (addr)
            `REG_CTRL: ctrl_q <= wdata[6:0];
            `REG_IDS: begin
               did_q <= wdata[7:0];
               sdid_q <= wdata[15:8];
            end
            `REG_LINE: begin
               ovr_line_q <= wdata[10:0];
               ovr_en_q <= wdata[`LINE_OVR];
            end
            `REG_LOC: loc_q <= wdata[11:0];
            default: ;
         endcase
      end
   end

   // Read data stands in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            `REG_CTRL: rdata <= {25'h0, ctrl_q};
            `REG_IDS: rdata <= {16'h0, sdid_q, did_q};
            `REG_LINE: rdata <= {15'h0, ovr_en_q, 5'h0, ovr_line_q};
            `REG_LOC: rdata <= {20'h0, loc_q};
            `REG_STAT: rdata <= {16'h0, pkt_cnt_q, 7'h0, tc_valid_q};
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

   // Source select: the other input is never looked at
   assign sel_tc = ctrl_q[`CTRL_GPI] ? gpi_tc : ser_tc;

   // Timecode capture; a source switch drops validity, a strobe wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tc_q <= 64'h0;
         tc_valid_q <= 1'b0;
      end else begin
         if (wr && addr == `REG_CTRL &&
             wdata[`CTRL_GPI] != ctrl_q[`CTRL_GPI]) begin
            tc_valid_q <= 1'b0;
         end
         if (sel_tc.stb) begin
            tc_q <= sel_tc.bits;
            tc_valid_q <= 1'b1;
         end
      end
   end

   // Frame pair phase for high-rate progressive, toggled per frame
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pair_q <= 1'b0;
      end else if (fire && in_word.sof) begin
         pair_q <= ~pair_q;
      end
   end

   // Word position inside horizontal blanking
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hpos_q <= 12'h000;
      end else if (fire) begin
         hpos_q <= in_word.hblank ? 12'(hpos_q + 12'h001) : 12'h000;
      end
   end

   // Target lines: format defaults unless software overrides them
   always_comb begin
      line_b_en = ctrl_q[`CTRL_VITC];
      case (fmt)
         anc_tc_pkg::FMT_480I: begin
            line_a = `L480_F1;
            line_b = `L480_F2;
            line_b_en = 1'b1;
         end
         anc_tc_pkg::FMT_576I: begin
            line_a = `L576_F1;
            line_b = `L576_F2;
            line_b_en = 1'b1;
         end
         anc_tc_pkg::FMT_HDI: begin
            line_a = `LHD_LTC;
            line_b = `LHDI_V2;
         end
         default: begin
            line_a = `LHD_LTC;
            line_b = `LHDP_V2;
         end
      endcase
      if (ovr_en_q) begin
         line_a = ovr_line_q;
         line_b_en = 1'b0;
      end
   end

   // Field mark value and position
   always_comb begin
      if (fmt != anc_tc_pkg::FMT_HDP) begin
         fm_val = in_word.field;
      end else begin
         fm_val = ctrl_q[`CTRL_HIRATE] & pair_q;
      end
      fm_pos = ctrl_q[`CTRL_R25] ? `FM_25 : `FM_30;
      tc_fm = tc_q;
      tc_fm[fm_pos] = fm_val;
   end

   // Packet start; without valid timecode no packet starts, but one already under way runs to its end
   assign active = ctrl_q[`CTRL_EN] && tc_valid_q;
   assign hit = active && fire && st_q == anc_tc_pkg::ST_IDLE &&
                in_word.hblank && hpos_q == loc_q &&
                (in_word.line == line_a ||
                 (line_b_en && in_word.line == line_b));
   assign sending = hit || (st_q == anc_tc_pkg::ST_SEND && fire);
   assign cur_idx = (st_q == anc_tc_pkg::ST_SEND) ? idx_q : 5'h00;
   assign nxt_idx = 5'(cur_idx + (is_sd ? 5'h02 : 5'h01));
   assign t_use = (st_q == anc_tc_pkg::ST_SEND) ? ptc_q : tc_fm;

   // Checksum over DID through the last user word, nine bits
   always_comb begin
      logic [8:0] sum;
      logic [9:0] wd;
      sum = 9'h000;
      wd = 10'h000;
      for (int i = `IX_DID; i < `IX_CS; i++) begin
         wd = pkt_word(5'(i), tc_fm, did_q, sdid_q);
         sum = 9'(sum + wd[8:0]); // Parity bit 9 stays out of the sum
      end
      cs_new = {~sum[8], sum};
   end
   assign cs_use = (st_q == anc_tc_pkg::ST_SEND) ? cs_q : cs_new;

   // Words for the current slot and the one after it
   always_comb begin
      w0 = (cur_idx == `IX_CS) ? cs_use :
           pkt_word(cur_idx, t_use, did_q, sdid_q);
      w1 = (5'(cur_idx + 5'h01) == `IX_CS) ? cs_use :
           pkt_word(5'(cur_idx + 5'h01), t_use, did_q, sdid_q);
   end

   // Overlay the packet words on the passing stream
   always_comb begin
      mod_word = in_word;
      if (sending) begin
         if (is_sd) begin
            mod_word.c = w0;
            if (5'(cur_idx + 5'h01) < `PKT_LEN) begin
               mod_word.y = w1;
            end
         end else begin
            mod_word.y = w0;
         end
      end
   end

   // Packet sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= anc_tc_pkg::ST_IDLE;
         idx_q <= 5'h00;
      end else if (sending) begin
         idx_q <= nxt_idx;
         st_q <= (nxt_idx >= `PKT_LEN) ? anc_tc_pkg::ST_IDLE :
                 anc_tc_pkg::ST_SEND;
      end
   end

   // Payload and checksum frozen for the length of one packet
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptc_q <= 64'h0;
         cs_q <= 10'h000;
         pkt_cnt_q <= 8'h00;
      end else if (hit) begin
         ptc_q <= tc_fm;
         cs_q <= cs_new;
         pkt_cnt_q <= 8'(pkt_cnt_q + 8'h01);
      end
   end

   // A stall downstream holds the input, so no word is lost
   skid2 #(.WIDTH($bits(anc_tc_pkg::vid_t))) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(mod_word),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_word)
   );

   AST_IDLE_PASS: assert property (@(posedge clock)
      disable iff (!rst_n) !active |-> mod_word == in_word)
      else $error("stream altered while inactive");
   AST_FM_INTERLACED: assert property (@(posedge clock)
      disable iff (!rst_n)
      hit && fmt != anc_tc_pkg::FMT_HDP |=> ptc_q[fm_pos] ==
      $past(in_word.field))
      else $error("field mark differs from field");
   AST_FM_LOWRATE: assert property (@(posedge clock)
      disable iff (!rst_n)
      hit && fmt == anc_tc_pkg::FMT_HDP && !ctrl_q[`CTRL_HIRATE]
      |=> !ptc_q[fm_pos])
      else $error("field mark set at low rate");
   AST_FM_POS: assert property (@(posedge clock)
      disable iff (!rst_n)
      fm_pos == (ctrl_q[`CTRL_R25] ? 6'h3b : 6'h1b))
      else $error("field mark position wrong");
   AST_TC_COPY: assert property (@(posedge clock)
      disable iff (!rst_n)
      hit |=> (ptc_q ^ $past(tc_q)) == (64'h1 << $past(fm_pos)) ||
      ptc_q == $past(tc_q))
      else $error("timecode altered beyond field mark");
   AST_UNSEL_IGNORED: assert property (@(posedge clock)
      disable iff (!rst_n)
      !sel_tc.stb |=> tc_q == $past(tc_q))
      else $error("timecode taken from unselected input");
   AST_HD_LUMA: assert property (@(posedge clock)
      disable iff (!rst_n)
      !is_sd |-> mod_word.c == in_word.c)
      else $error("chroma altered in HD");
   AST_DID: assert property (@(posedge clock)
      disable iff (!rst_n)
      sending && !is_sd && cur_idx == `IX_DID |->
      mod_word.y[7:0] == did_q)
      else $error("DID word wrong");
   AST_SD_CHROMA: assert property (@(posedge clock)
      disable iff (!rst_n)
      hit && is_sd |-> mod_word.c == `ADF0 && mod_word.y == `ADF1)
      else $error("SD packet start wrong");
endmodule : anc_timecode_inserter

// >>> testbench/tc_source_model.sv
// Timecode source and video sink standing beside the inserter
`timescale 1ns/1ps
module tc_source_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic send_ser,
   input wire logic send_gpi,
   input wire logic [63:0] tc,
   input wire logic [1:0] sink_mode,
   output anc_tc_pkg::tc_in_t ser_tc,
   output anc_tc_pkg::tc_in_t gpi_tc,
   output logic out_ready
);
   logic toggle_q;

   // Payload only means something beside the strobe, so it flips otherwise
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ser_tc <= '0;
         gpi_tc <= '0;
      end else begin
         ser_tc.stb <= send_ser;
         gpi_tc.stb <= send_gpi;
         ser_tc.bits <= send_ser ? tc : ~ser_tc.bits;
         gpi_tc.bits <= send_gpi ? tc : ~gpi_tc.bits;
      end
   end

   // Sink: 0 always ready, 1 ready every other cycle, 2 stalled
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         toggle_q <= 1'b0;
      end else begin
         toggle_q <= ~toggle_q;
      end
   end
   assign out_ready = (sink_mode == 2'd0) || (sink_mode == 2'd1 && toggle_q);
endmodule : tc_source_model

// >>> testbench/tb_top.sv
// Self-checking bench for the ancillary timecode inserter
`include "anc_tc_params.svh"
`timescale 1ns/1ps
module tb_top;
   localparam logic [63:0] TC = 64'h0123_4567_89ab_cdef;
   localparam int SD_LINE [4] = '{12, 275, 8, 321};
   logic clock, rst_n, wr, rd, in_valid, in_ready, out_valid, out_ready;
   logic send_ser, send_gpi;
   logic [1:0] sink_mode;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rv;
   anc_tc_pkg::vid_t in_word, out_word;
   anc_tc_pkg::vid_t q [$];
   anc_tc_pkg::tc_in_t ser_tc, gpi_tc;
   int fail_count = 0;
   int num_checks = 0;

   anc_timecode_inserter dut (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ser_tc(ser_tc),
      .gpi_tc(gpi_tc), .in_valid(in_valid), .in_ready(in_ready),
      .in_word(in_word), .out_valid(out_valid), .out_ready(out_ready),
      .out_word(out_word));

   tc_source_model src (.clock(clock), .rst_n(rst_n), .send_ser(send_ser),
      .send_gpi(send_gpi), .tc(TC), .sink_mode(sink_mode),
      .ser_tc(ser_tc), .gpi_tc(gpi_tc), .out_ready(out_ready));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Collect every word the sink takes
   always @(posedge clock) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_word);
   end

   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic bail();
      fail_count++;
      print_verdict();
   endtask : bail

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic send_tc(input logic gpi);
      @(posedge clock);
      send_ser <= !gpi;
      send_gpi <= gpi;
      @(posedge clock);
      send_ser <= 1'b0;
      send_gpi <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : send_tc

   // One line of blanking words; y and c carry their own position
   // A closing active word restarts the blanking count for the next line
   task automatic run_line(input logic [10:0] ln, input logic fld,
                           input logic sof);
      int w;
      q.delete();
      @(posedge clock);
      for (int i = 0; i < 31; i++) begin
         in_valid <= 1'b1;
         in_word <= {sof && i == 0, fld, i < 30, ln, 10'h200 + 10'(i),
                     10'h100 + 10'(i)};
         w = 0;
         do begin
            @(negedge clock);
            w++;
         end while (in_ready !== 1'b1 && w < 200);
         @(posedge clock);
         if (w >= 200) bail();
      end
      in_valid <= 1'b0;
      w = 0;
      while (q.size() < 31 && w < 400) begin
         @(posedge clock);
         w++;
      end
      if (q.size() < 31) bail();
   endtask : run_line

   task automatic chk_pass();
      for (int i = 0; i < 30; i++) begin
         check(q[i].y, 10'h100 + i);
      end
   endtask : chk_pass

   // HD packet at word offset 2 of the luma channel
   task automatic chk_hd(input int fk, input logic fm);
      logic [3:0] nib;
      logic [7:0] b;
      logic [8:0] sum;
      // Nine-bit sum of DID, SDID and count words, parity bit included
      sum = {^8'h5a, 8'h5a} + {^8'h3c, 8'h3c} + {^8'h10, 8'h10};
      check(q[1].y, 10'h101);
      check(q[2].y, 10'h000);
      check(q[3].y, 10'h3ff);
      check(q[4].y, 10'h3ff);
      check(q[5].y[7:0], 8'h5a);
      check(q[6].y[7:0], 8'h3c);
      check(q[7].y[7:0], 8'h10);
      check(q[2].c, 10'h202);
      for (int k = 0; k < 16; k++) begin
         nib = TC[4*k +: 4];
         if (k == fk) nib[3] = fm;
         check(q[8+k].y[7:4], nib);
         b = {nib, 4'h0};
         sum = sum + {^b, b};
      end
      check(q[24].y, {~sum[8], sum});
   endtask : chk_hd

   task automatic regs_reset();
      logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
      for (int i = 0; i < 6; i++) begin
         rd_reg(a[i], rv);
         check(rv, i == 1 ? 32'h6060 : 32'h0);
      end
      wr_reg(8'h14, 32'hffff_ffff);
      rd_reg(8'h14, rv);
      check(rv, 32'h0);
      wr_reg(`REG_IDS, 32'h3c5a);
      rd_reg(`REG_IDS, rv);
      check(rv[15:0], 16'h3c5a);
      wr_reg(`REG_LOC, 32'h2);
   endtask : regs_reset

   task automatic idle_pass();
      wr_reg(`REG_CTRL, 32'h18);
      run_line(10, 1'b0, 1'b0);
      chk_pass();
      wr_reg(`REG_CTRL, 32'h19);
      send_tc(1'b1);
      rd_reg(`REG_STAT, rv);
      check(rv[0], 1'b0);
      run_line(10, 1'b0, 1'b0);
      chk_pass();
   endtask : idle_pass

   task automatic ltc_packet();
      send_tc(1'b0);
      rd_reg(`REG_STAT, rv);
      check(rv[0], 1'b1);
      sink_mode <= 2'd1;
      run_line(10, 1'b0, 1'b0);
      chk_hd(6, 1'b0);
      sink_mode <= 2'd0;
      rd_reg(`REG_STAT, rv);
      check(rv[15:8], 8'h01);
   endtask : ltc_packet

   task automatic vitc_pair();
      wr_reg(`REG_CTRL, 32'h11);
      run_line(571, 1'b1, 1'b0);
      chk_pass();
      wr_reg(`REG_CTRL, 32'h53);
      run_line(571, 1'b1, 1'b0);
      chk_hd(14, 1'b1);
      run_line(10, 1'b0, 1'b0);
      chk_hd(14, 1'b0);
      wr_reg(`REG_CTRL, 32'h1b);
      run_line(9, 1'b0, 1'b0);
      chk_hd(6, 1'b0);
   endtask : vitc_pair

   // Above 30Hz the two frames of a pair carry opposite marks
   task automatic frame_pair();
      logic a;
      wr_reg(`REG_CTRL, 32'h39);
      run_line(10, 1'b0, 1'b1);
      a = q[14].y[7];
      run_line(10, 1'b0, 1'b1);
      check(a ^ q[14].y[7], 1'b1);
   endtask : frame_pair

   task automatic line_override();
      wr_reg(`REG_CTRL, 32'h19);
      wr_reg(`REG_LINE, 32'h1_0020);
      run_line(32, 1'b0, 1'b0);
      chk_hd(6, 1'b0);
      run_line(10, 1'b0, 1'b0);
      chk_pass();
      wr_reg(`REG_LINE, 32'h0);
   endtask : line_override

   // SD packets interleave chroma then luma
   task automatic sd_lines();
      wr_reg(`REG_CTRL, 32'h05);
      rd_reg(`REG_STAT, rv);
      check(rv[0], 1'b0);
      send_tc(1'b1);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`REG_CTRL, 32'(5 + 8 * (i / 2)));
         run_line(11'(SD_LINE[i]), 1'(i % 2), 1'b0);
         check(q[2].c, 10'h000);
         check(q[2].y, 10'h3ff);
         check(q[3].c, 10'h3ff);
         check(q[3].y[7:0], 8'h5a);
      end
   endtask : sd_lines

   // A stalled sink must cause refusal, then every word drains in order
   task automatic stall_drain();
      int acc;
      int w;
      acc = 0;
      w = 0;
      q.delete();
      @(posedge clock);
      sink_mode <= 2'd2;
      in_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         in_word <= {3'b001, 11'd100, 10'h200 + 10'(i), 10'h100 + 10'(i)};
         @(negedge clock);
         if (in_ready !== 1'b1) break;
         @(posedge clock);
         acc++;
      end
      @(posedge clock);
      in_valid <= 1'b0;
      sink_mode <= 2'd0;
      check(acc < 8, 1'b1);
      while (q.size() < acc && w < 100) begin
         @(posedge clock);
         w++;
      end
      check(q.size(), acc);
      if (q.size() < acc) bail();
      for (int i = 0; i < acc && i < q.size(); i++) begin
         check(q[i].y, 10'h100 + i);
      end
   endtask : stall_drain

   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      in_valid = 1'b0;
      in_word = '0;
      send_ser = 1'b0;
      send_gpi = 1'b0;
      sink_mode = 2'd0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      regs_reset();
      idle_pass();
      ltc_packet();
      vitc_pair();
      frame_pair();
      line_override();
      sd_lines();
      stall_drain();
      print_verdict();
   end
endmodule : tb_top
